// ### cld_regs.vh
// cld_regs.vh: constants for the cascaded line delay buffer
// assumes inclusion by bare name from the design files of this block
`ifndef CLD_REGS_VH
`define CLD_REGS_VH

// default sample width in bits
`define CLD_WIDTH 8
// default number of chained line buffers
`define CLD_NUM_BUFS 3
// default line length in samples
`define CLD_LINE_LEN 720
// widest sample allowed and most buffers allowed
`define CLD_MAX_WIDTH 64
`define CLD_MAX_BUFS 16
// depth of the output skid buffer
`define CLD_SKID_DEPTH 2

`endif

// ### cld_skid_buf.v
// cld_skid_buf.v: two-entry buffer with valid and ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`include "cld_regs.vh"

module cld_skid_buf #(
	parameter WIDTH = `CLD_WIDTH
) (
	// clock and reset
	input wire sys_clk_in,
	input wire rstn_in,
	// filling side
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	// draining side
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_r [0:`CLD_SKID_DEPTH-1];
	reg wr_ptr_r;
	reg rd_ptr_r;
	reg [1:0] count_r;
	wire push;
	wire pop;

	assign in_ready_out = (count_r != 2'h2);
	assign out_valid_out = (count_r != 2'h0);
	assign out_data_out = mem_r[rd_ptr_r];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	// data storage is not reset; only the pointers and occupancy are control state
	always @(posedge sys_clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			if (push && !pop) begin
				count_r <= count_r + 2'h1;
			end else if (pop && !push) begin
				count_r <= count_r - 2'h1;
			end
		end
	end
endmodule // cld_skid_buf

// ### cld_line_delay.v
// cld_line_delay.v: chain of equal-length line delay buffers with joined taps
// assumes an upstream source that qualifies each sample with the strobe
// Operation
// R1: usable after synchronous reset release; buffer contents and taps undefined
// R2: with strobe high, input sample enters first slot of first buffer; the code takes it only while ready_out is high
// R3: every enabled cycle all stored values advance exactly one slot together
// R4: sample reaches first buffer end after LINE_LEN enabled cycles
// R5: each buffer end feeds the next buffer's first slot, one chain
// R6: sample reaches buffer k end after k times LINE_LEN enabled cycles
// R7: first buffer drives lowest output slice, last buffer the highest
// R8: with strobe low input is ignored and all slots hold
// R9: with strobe low the joined output keeps its values
// R10: source raises strobe with each sample it wants taken
// R11: one to sixteen buffers, sample width up to 64 bits
// R12: joined width is buffer count times sample width, readable anytime
// R13: line length is one build parameter shared by all buffers
`timescale 1ns/10ps
`include "cld_regs.vh"

module cld_line_delay #(
	parameter WIDTH = `CLD_WIDTH,
	parameter NUM_BUFS = `CLD_NUM_BUFS,
	parameter LINE_LEN = `CLD_LINE_LEN
) (
	// clock and reset
	input wire sys_clk_in,
	input wire rstn_in,
	// sample input
	input wire advance_in,
	input wire [WIDTH-1:0] sample_in,
	// joined taps, readable at any time
	output reg [NUM_BUFS*WIDTH-1:0] taps_out,
	// stream copy of each enabled tap word
	output reg taps_valid_out,
	input wire taps_ready_in,
	output reg [NUM_BUFS*WIDTH-1:0] taps_data_out,
	// stream back-pressure towards the source
	output reg ready_out
);
	localparam TOTAL = NUM_BUFS * LINE_LEN;
	localparam TAPW = NUM_BUFS * WIDTH;

	// bad sizes turn size_check into a two-bit [-1:0] vector, which still elaborates
	localparam SIZE_OK = (NUM_BUFS >= 1) && (NUM_BUFS <= `CLD_MAX_BUFS) &&
		(WIDTH >= 1) && (WIDTH <= `CLD_MAX_WIDTH) && (LINE_LEN >= 1); // R11
	wire [SIZE_OK ? 0 : -1:0] size_check;
	assign size_check = 1'b0;

	// one flat shift chain; slot j*LINE_LEN-1 is the end of buffer j
	reg [WIDTH-1:0] chain_r [0:TOTAL-1]; // R13
	wire stall;
	wire step;
	wire sb_in_ready;
	wire sb_out_valid;
	wire sb_out_ready;
	wire sb_pop;
	wire [TAPW-1:0] sb_out_data;
	wire [TAPW-1:0] tap_nxt;
	wire [1:0] occ_nxt;
	reg [1:0] occ_r;

	// the stall comes from the registered ready so that the source sees
	// exactly the flag that gates each step; no tap word is ever lost
	assign stall = ~ready_out;
	assign step = advance_in & ~stall & sb_in_ready; // R8
	assign sb_pop = sb_out_valid & sb_out_ready;
	assign occ_nxt = occ_r + {1'b0, step} - {1'b0, sb_pop};

	// no reset on the chain: contents start undefined by design
	always @(posedge sys_clk_in) begin
		if (step) begin
			chain_r[0] <= sample_in; // R2
		end
	end

	genvar i;
	generate
		for (i = 1; i < TOTAL; i = i + 1) begin : g_shift
			always @(posedge sys_clk_in) begin
				if (step) begin
					chain_r[i] <= chain_r[i-1]; // R3 R5
				end
			end
		end
		for (i = 0; i < NUM_BUFS; i = i + 1) begin : g_tap
			// buffer i output lands in slice i, lowest first
			assign tap_nxt[i*WIDTH +: WIDTH] =
				chain_r[(i+1)*LINE_LEN-1]; // R4 R6 R7 R12
		end
	endgenerate

	// the tap register mirrors the chain ends; it updates only on a step
	// so a sample shows in the buffer k tap after k*LINE_LEN steps plus one more step
	always @(posedge sys_clk_in) begin
		if (step) begin
			taps_out <= tap_nxt; // R9
		end
	end

	// skid occupancy mirror, used to raise ready one cycle ahead
	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			occ_r <= 2'h0;
		end else begin
			occ_r <= occ_nxt;
		end
	end

	// the word pushed is the one taps_out takes at the same step
	cld_skid_buf #(
		.WIDTH(TAPW)
	) u_skid (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.in_valid_in(step),
		.in_ready_out(sb_in_ready),
		.in_data_in(tap_nxt),
		.out_valid_out(sb_out_valid),
		.out_ready_in(sb_out_ready),
		.out_data_out(sb_out_data)
	);

	// registered output stage: holds a word until the reader takes it
	wire out_load;
	assign sb_out_ready = ~taps_valid_out | taps_ready_in;
	assign out_load = sb_out_valid & sb_out_ready;

	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			taps_valid_out <= 1'b0;
			taps_data_out <= {TAPW{1'b0}};
			ready_out <= 1'b0; // R1
		end else begin
			ready_out <= (occ_nxt != 2'h2);
			if (out_load) begin
				taps_valid_out <= 1'b1;
				taps_data_out <= sb_out_data;
			end else if (taps_ready_in) begin
				taps_valid_out <= 1'b0;
			end
		end
	end
endmodule // cld_line_delay

// ### cld_line_delay_sva.sv
// cld_line_delay_sva.sv: checker for the line delay chain
// assumes it is bound to cld_line_delay
`timescale 1ns/10ps
module cld_line_delay_sva #(
	parameter WIDTH = 8,
	parameter NUM_BUFS = 3
) (
	// clock and reset
	input wire sys_clk_in,
	input wire rstn_in,
	// watched ports
	input wire advance_in,
	input wire [NUM_BUFS*WIDTH-1:0] taps_out,
	input wire taps_valid_out,
	input wire taps_ready_in,
	input wire [NUM_BUFS*WIDTH-1:0] taps_data_out,
	input wire ready_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	// six refused cycles are more than the two-entry skid can absorb
	sequence s_stall;
		(advance_in && !taps_ready_in)[*6];
	endsequence
	a_taps_hold: assert property ($past(rstn_in) && !advance_in |=>
		$stable(taps_out)) else $error("taps moved");
	a_reset_quiet: assert property (disable iff (1'b0) !rstn_in |=>
		!taps_valid_out && taps_data_out == '0) else $error("reset");
	a_ready_up: assert property ($rose(rstn_in) |-> ##[1:2] ready_out)
		else $error("no ready");
	a_valid_hold: assert property (taps_valid_out && !taps_ready_in |=>
		taps_valid_out) else $error("valid lost");
	a_data_hold: assert property (taps_valid_out && !taps_ready_in |=>
		$stable(taps_data_out)) else $error("data moved");
	a_stall_flag: assert property (s_stall |-> !ready_out)
		else $error("no stall");
	a_valid_rise: assert property (advance_in && ready_out &&
		!taps_valid_out |-> ##[1:2] taps_valid_out) else $error("no word");
	a_idle_quiet: assert property ((!advance_in && !taps_valid_out)[*3]
		|=> !taps_valid_out) else $error("word from nothing");
endmodule // cld_line_delay_sva
bind cld_line_delay cld_line_delay_sva #(.WIDTH(WIDTH),
	.NUM_BUFS(NUM_BUFS)) u_sva (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
	.advance_in(advance_in), .taps_out(taps_out), .ready_out(ready_out),
	.taps_valid_out(taps_valid_out), .taps_ready_in(taps_ready_in),
	.taps_data_out(taps_data_out));

// ### cld_src_model.sv
// cld_src_model.sv: upstream source, sample value counts taken steps
// assumes ready_in high marks a step the block takes
`timescale 1ns/10ps
module cld_src_model (
	// clock and control
	input wire sys_clk_in,
	input wire go_in,
	input wire ready_in,
	// sample side
	output logic advance_out,
	output logic [7:0] sample_out
);
	initial advance_out = 1'b0;
	initial sample_out = 8'h00;
	// strobe stays up while refused, the same sample is offered again
	always @(posedge sys_clk_in) begin
		advance_out <= go_in;
		if (advance_out && ready_in)
			sample_out <= sample_out + 8'h01;
	end
endmodule // cld_src_model

// ### cld_line_delay_test.sv
// cld_line_delay_test.sv: self-checking bench for the line delay chain
// assumes the source model and the bound checker are compiled first
`timescale 1ns/10ps
module cld_line_delay_test;
	localparam L = 4;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic go = 1'b0;
	logic rdy = 1'b1;
	logic [23:0] keep;
	wire adv, tv, ro;
	wire [7:0] smp;
	wire [23:0] taps, td;
	int fails = 0;
	int checks_done = 0;
	int n;
	initial forever #4 sys_clk_in = ~sys_clk_in;
	cld_src_model u_cld_src_model (.sys_clk_in(sys_clk_in), .go_in(go),
		.ready_in(ro), .advance_out(adv), .sample_out(smp));
	cld_line_delay #(.LINE_LEN(L)) u_cld_line_delay (.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in), .advance_in(adv), .sample_in(smp), .taps_out(taps),
		.taps_valid_out(tv), .taps_ready_in(rdy), .taps_data_out(td),
		.ready_out(ro));
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// slice k-1 shows the sample taken k lines before the newest one
	task chk_chain;
		for (int k = 1; k <= 3; k++)
			if (smp > k*L) cmp(taps[k*8-1 -: 8], 8'(smp-1-k*L));
	endtask
	task t_stream;
		go <= 1'b1;
		repeat (16) begin
			@(posedge sys_clk_in);
			#1 chk_chain();
			if (tv) cmp(td[7:0], keep[7:0]);
			keep = taps;
		end
		$display("test stream done");
	endtask
	task t_hold;
		@(posedge sys_clk_in);
		go <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		#1 keep = taps;
		repeat (5) @(posedge sys_clk_in);
		#1 for (int k = 0; k < 3; k++) cmp(taps[k*8+:8], keep[k*8+:8]);
		chk_chain();
		$display("test hold done");
	endtask
	task t_stall;
		@(posedge sys_clk_in);
		rdy <= 1'b0;
		go <= 1'b1;
		for (n = 0; n < 20 && ro !== 1'b0; n++) @(posedge sys_clk_in) #1;
		if (n == 20) begin fails++; end_of_test(); end
		repeat (4) @(posedge sys_clk_in);
		#1 cmp({7'h0, tv}, 8'h01);
		chk_chain();
		@(posedge sys_clk_in);
		rdy <= 1'b1;
		go <= 1'b0;
		for (n = 0; n < 20 && tv !== 1'b0; n++) @(posedge sys_clk_in) #1;
		if (n == 20) begin fails++; end_of_test(); end
		#1 chk_chain();
		$display("test stall done");
	endtask
	initial begin
		repeat (6) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		t_stream();
		t_hold();
		t_stall();
		end_of_test();
	end
endmodule // cld_line_delay_test
